/* File: src/pin_mux_top.sv */
// module: pin routing for host, uart, pulse and timer pin groups
`timescale 1ns/10ps
module pin_mux_top (
  input logic aclk,
  input logic aresetn,
  input logic [pm_pkg::ADDR_W-1:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  input logic [pm_pkg::ADDR_W-1:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready,
  input logic [pm_pkg::HOST_PINS-1:0] host_pad_in,
  output logic [pm_pkg::HOST_PINS-1:0] host_pad_out,
  output logic [pm_pkg::HOST_PINS-1:0] host_pad_oe,
  input logic [pm_pkg::HOST_PINS-1:0] host_gpio_out,
  input logic [pm_pkg::HOST_PINS-1:0] host_gpio_oe,
  output logic [pm_pkg::HOST_PINS-1:0] host_gpio_in,
  input logic [pm_pkg::HOST_PINS-1:0] hpi_out,
  input logic [pm_pkg::HOST_PINS-1:0] hpi_oe,
  output logic [pm_pkg::HOST_PINS-1:0] hpi_in,
  input logic [pm_pkg::LINK_PINS-1:0] link_out,
  input logic [pm_pkg::LINK_PINS-1:0] link_oe,
  output logic [pm_pkg::LINK_PINS-1:0] link_in,
  input logic [pm_pkg::ETH_PINS-1:0] eth_out,
  input logic [pm_pkg::ETH_PINS-1:0] eth_oe,
  output logic [pm_pkg::ETH_PINS-1:0] eth_in,
  input logic [pm_pkg::MISC_PINS-1:0] misc_pad_in,
  output logic [pm_pkg::MISC_PINS-1:0] misc_pad_out,
  output logic [pm_pkg::MISC_PINS-1:0] misc_pad_oe,
  input logic [pm_pkg::MISC_PINS-1:0] misc_gpio_out,
  input logic [pm_pkg::MISC_PINS-1:0] misc_gpio_oe,
  output logic [pm_pkg::MISC_PINS-1:0] misc_gpio_in,
  output logic uart_receive_data,
  input logic uart_transmit_data,
  output logic uart_clear_to_send,
  input logic uart_request_to_send,
  input logic pulse_output_a,
  output logic timer_a_input,
  input logic timer_a_output,
  output logic serial_port_ext_clock,
  output logic timer_b_input,
  input logic timer_b_output
);
  pin_cfg_if cfg ();

  pin_mux_regs u_regs (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .cfg(cfg.regs)
  );

  // link and ethernet sit in disjoint pin zones, so one vector serves both
  logic [pm_pkg::HOST_PINS-1:0] ext_out, ext_oe, ext_in;
  logic host_up;
  assign ext_out = {eth_out, link_out};
  assign ext_oe = {eth_oe, link_oe};
  assign link_in = ext_in[pm_pkg::LINK_PINS-1:0];
  assign eth_in = ext_in[pm_pkg::HOST_PINS-1:pm_pkg::LINK_PINS];
  assign host_up = !cfg.pd[pm_pkg::PD_HOST];

  for (genvar i = 0; i < pm_pkg::HOST_PINS; i++)
  begin : g_host
    pm_pkg::pin_fn_type fn;
    logic link_zone, val, drv;
    assign link_zone = (i < pm_pkg::LINK_PINS);
    always_comb
    begin
      case (cfg.host_group_select)
        pm_pkg::HOST_HPI:
          fn = (i != 0) ? pm_pkg::FN_HOST_PORT : pm_pkg::FN_GPIO;
        pm_pkg::HOST_LINK:
          fn = link_zone ? pm_pkg::FN_SERIAL_LINK : pm_pkg::FN_GPIO;
        pm_pkg::HOST_BOTH:
          fn = link_zone ? pm_pkg::FN_SERIAL_LINK
                         : pm_pkg::FN_ETHERNET;
        pm_pkg::HOST_ETH:
          fn = link_zone ? pm_pkg::FN_GPIO : pm_pkg::FN_ETHERNET;
        default:
          fn = pm_pkg::FN_GPIO;
      endcase
    end
    assign val = (fn == pm_pkg::FN_HOST_PORT) ? hpi_out[i] :
                 (fn == pm_pkg::FN_GPIO) ? host_gpio_out[i] : ext_out[i];
    assign drv = (fn == pm_pkg::FN_HOST_PORT) ? hpi_oe[i] :
                 (fn == pm_pkg::FN_GPIO) ? host_gpio_oe[i] : ext_oe[i];
    // a powered-down pad neither drives nor passes its level inward
    assign host_pad_out[i] = val && host_up;
    assign host_pad_oe[i] = drv && host_up;
    assign hpi_in[i] = host_pad_in[i] && host_up &&
                       fn == pm_pkg::FN_HOST_PORT;
    assign ext_in[i] = host_pad_in[i] && host_up &&
                       (fn == pm_pkg::FN_SERIAL_LINK ||
                        fn == pm_pkg::FN_ETHERNET);
    assign host_gpio_in[i] = host_pad_in[i] && host_up &&
                             fn == pm_pkg::FN_GPIO;
  end

  logic [pm_pkg::MISC_PINS-1:0] misc_fn, misc_drv, misc_val, misc_up;
  logic [pm_pkg::MISC_PINS-1:0] misc_fin;
  logic clk_sel;
  assign clk_sel = cfg.timer_a_group_select == pm_pkg::TIMA_CLOCK;
  assign misc_up = ~{{2{cfg.pd[pm_pkg::PD_TIMB]}},
                     {2{cfg.pd[pm_pkg::PD_TIMA]}},
                     {2{cfg.pd[pm_pkg::PD_FLOW]}},
                     {2{cfg.pd[pm_pkg::PD_UDATA]}}};

  // reserved codes fall through and leave the pins on GPIO
  always_comb
  begin
    misc_fn = '0;
    if (cfg.uart_data_group_select == pm_pkg::UDATA_UART)
    begin
      misc_fn[pm_pkg::P_RX] = 1'b1;
      misc_fn[pm_pkg::P_TX] = 1'b1;
    end
    case (cfg.uart_flow_group_select)
      pm_pkg::FLOW_UART:
      begin
        misc_fn[pm_pkg::P_CTS] = 1'b1;
        misc_fn[pm_pkg::P_RTS] = 1'b1;
      end
      pm_pkg::FLOW_PWM:
        misc_fn[pm_pkg::P_RTS] = 1'b1;
      default:
        misc_fn[pm_pkg::P_CTS] = 1'b0;
    endcase
    case (cfg.timer_a_group_select)
      pm_pkg::TIMA_TIMER, pm_pkg::TIMA_CLOCK:
      begin
        misc_fn[pm_pkg::P_TOUT] = 1'b1;
        misc_fn[pm_pkg::P_TIN] = 1'b1;
      end
      default:
        misc_fn[pm_pkg::P_TIN] = 1'b0;
    endcase
    if (cfg.timer_b_group_select == pm_pkg::TIMB_TIMER)
    begin
      misc_fn[pm_pkg::P_TOUT_B] = 1'b1;
      misc_fn[pm_pkg::P_TIN_B] = 1'b1;
    end
  end

  // the clock-input setting turns the timer output pin into an input
  always_comb
  begin
    misc_drv = pm_pkg::MISC_DRIVE;
    if (clk_sel)
      misc_drv[pm_pkg::P_TOUT] = 1'b0;
    misc_val = '0;
    misc_val[pm_pkg::P_TX] = uart_transmit_data;
    misc_val[pm_pkg::P_RTS] =
      (cfg.uart_flow_group_select == pm_pkg::FLOW_PWM) ?
      pulse_output_a : uart_request_to_send;
    misc_val[pm_pkg::P_TOUT] = timer_a_output;
    misc_val[pm_pkg::P_TOUT_B] = timer_b_output;
  end

  for (genvar j = 0; j < pm_pkg::MISC_PINS; j++)
  begin : g_misc
    assign misc_pad_out[j] = misc_up[j] &&
      (misc_fn[j] ? misc_val[j] : misc_gpio_out[j]);
    assign misc_pad_oe[j] = misc_up[j] &&
      (misc_fn[j] ? misc_drv[j] : misc_gpio_oe[j]);
    assign misc_fin[j] = misc_up[j] && misc_fn[j] && misc_pad_in[j];
    assign misc_gpio_in[j] = misc_up[j] && !misc_fn[j] &&
                             misc_pad_in[j];
  end

  assign uart_receive_data = misc_fin[pm_pkg::P_RX];
  assign uart_clear_to_send = misc_fin[pm_pkg::P_CTS];
  assign timer_a_input = misc_fin[pm_pkg::P_TIN];
  assign serial_port_ext_clock = misc_fin[pm_pkg::P_TOUT] && clk_sel;
  assign timer_b_input = misc_fin[pm_pkg::P_TIN_B];

  // a group reads as active when routed away from GPIO and powered
  logic [pm_pkg::PD_W-1:0] status_d, status_q;
  always_comb
  begin
    status_d = '0;
    status_d[pm_pkg::PD_HOST] = host_up &&
      cfg.host_group_select != pm_pkg::HOST_GPIO &&
      cfg.host_group_select <= pm_pkg::HOST_ETH;
    status_d[pm_pkg::PD_UDATA] = misc_up[pm_pkg::P_RX] &&
      misc_fn[pm_pkg::P_RX];
    status_d[pm_pkg::PD_FLOW] = misc_up[pm_pkg::P_RTS] &&
      misc_fn[pm_pkg::P_RTS];
    status_d[pm_pkg::PD_TIMA] = misc_up[pm_pkg::P_TIN] &&
      misc_fn[pm_pkg::P_TIN];
    status_d[pm_pkg::PD_TIMB] = misc_up[pm_pkg::P_TIN_B] &&
      misc_fn[pm_pkg::P_TIN_B];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_q <= '0;
    else
      status_q <= status_d;
  end
  assign cfg.status = status_q;

  localparam int LP = pm_pkg::LINK_PINS;
  localparam int HP = pm_pkg::HOST_PINS;

  property p_link_gpio;
    @(posedge aclk) disable iff (!aresetn)
      (cfg.host_group_select == pm_pkg::HOST_LINK && host_up) |->
        host_pad_out[LP-1:0] == link_out &&
        host_pad_oe[LP-1:0] == link_oe &&
        host_pad_out[HP-1:LP] == host_gpio_out[HP-1:LP];
  endproperty
  a_link_gpio: assert property (p_link_gpio)
    else $error("link setting routes host pins wrongly");
  property p_link_eth;
    @(posedge aclk) disable iff (!aresetn)
      (cfg.host_group_select == pm_pkg::HOST_BOTH && host_up) |->
        host_pad_out == {eth_out, link_out} &&
        host_gpio_in == '0;
  endproperty
  a_link_eth: assert property (p_link_eth)
    else $error("link plus ethernet setting routes wrongly");
  property p_eth_gpio;
    @(posedge aclk) disable iff (!aresetn)
      (cfg.host_group_select == pm_pkg::HOST_ETH && host_up) |->
        host_pad_out[HP-1:LP] == eth_out &&
        host_pad_oe[LP-1:0] == host_gpio_oe[LP-1:0] &&
        link_in == '0;
  endproperty
  a_eth_gpio: assert property (p_eth_gpio)
    else $error("ethernet setting routes wrongly");
  property p_hpi;
    @(posedge aclk) disable iff (!aresetn)
      (cfg.host_group_select == pm_pkg::HOST_HPI && host_up) |->
        host_pad_out[HP-1:1] == hpi_out[HP-1:1] &&
        host_pad_out[0] == host_gpio_out[0];
  endproperty
  a_hpi: assert property (p_hpi)
    else $error("host port setting routes wrongly");
  property p_host_reserved;
    @(posedge aclk) disable iff (!aresetn)
      (cfg.host_group_select > pm_pkg::HOST_ETH && host_up) |->
        host_pad_oe == host_gpio_oe && hpi_in == '0 && ext_in == '0;
  endproperty
  a_host_reserved: assert property (p_host_reserved)
    else $error("reserved host code left a peripheral routed");
  sequence s_host_down;
    !host_up [*2];
  endsequence
  property p_host_down;
    @(posedge aclk) disable iff (!aresetn)
      s_host_down |-> host_pad_oe == '0 && host_gpio_in == '0 &&
        hpi_in == '0 && !status_q[pm_pkg::PD_HOST];
  endproperty
  a_host_down: assert property (p_host_down)
    else $error("powered-down host pins still active");
  property p_uart_data;
    @(posedge aclk) disable iff (!aresetn)
      (cfg.uart_data_group_select && misc_up[pm_pkg::P_RX]) |->
        uart_receive_data == misc_pad_in[pm_pkg::P_RX] &&
        misc_pad_out[pm_pkg::P_TX] == uart_transmit_data &&
        misc_pad_oe[pm_pkg::P_TX] && !misc_pad_oe[pm_pkg::P_RX];
  endproperty
  a_uart_data: assert property (p_uart_data)
    else $error("uart data pins not routed");
  property p_uart_down;
    @(posedge aclk) disable iff (!aresetn)
      cfg.pd[pm_pkg::PD_UDATA] |->
        !uart_receive_data && misc_pad_oe[pm_pkg::P_TX] == 1'b0;
  endproperty
  a_uart_down: assert property (p_uart_down)
    else $error("powered-down uart data pins active");
  property p_flow_pwm;
    @(posedge aclk) disable iff (!aresetn)
      (cfg.uart_flow_group_select == pm_pkg::FLOW_PWM &&
       misc_up[pm_pkg::P_RTS]) |->
        misc_pad_out[pm_pkg::P_RTS] == pulse_output_a &&
        misc_gpio_in[pm_pkg::P_CTS] == misc_pad_in[pm_pkg::P_CTS] &&
        !uart_clear_to_send;
  endproperty
  a_flow_pwm: assert property (p_flow_pwm)
    else $error("pulse setting routes flow pins wrongly");
  property p_flow_down;
    @(posedge aclk) disable iff (!aresetn)
      cfg.pd[pm_pkg::PD_FLOW] |=> $past(cfg.pd[pm_pkg::PD_FLOW]) &&
        !status_q[pm_pkg::PD_FLOW];
  endproperty
  a_flow_down: assert property (p_flow_down)
    else $error("powered-down flow group shown active");
  property p_tima_clock;
    @(posedge aclk) disable iff (!aresetn)
      (clk_sel && misc_up[pm_pkg::P_TOUT]) |->
        !misc_pad_oe[pm_pkg::P_TOUT] &&
        serial_port_ext_clock == misc_pad_in[pm_pkg::P_TOUT] &&
        timer_a_input == misc_pad_in[pm_pkg::P_TIN];
  endproperty
  a_tima_clock: assert property (p_tima_clock)
    else $error("timer A clock setting routes wrongly");
  property p_tima_reserved;
    @(posedge aclk) disable iff (!aresetn)
      (cfg.timer_a_group_select == 2'h2) |->
        misc_fn[pm_pkg::P_TIN:pm_pkg::P_TOUT] == 2'h0; // leave the pins on gpio
  endproperty
  a_tima_reserved: assert property (p_tima_reserved)
    else $error("reserved timer A code left timer routed");
  property p_timb;
    @(posedge aclk) disable iff (!aresetn)
      (cfg.timer_b_group_select == pm_pkg::TIMB_TIMER &&
       !cfg.pd[pm_pkg::PD_TIMB]) |->
        misc_pad_out[pm_pkg::P_TOUT_B] == timer_b_output &&
        timer_b_input == misc_pad_in[pm_pkg::P_TIN_B];
  endproperty
  a_timb: assert property (p_timb)
    else $error("timer B setting routes wrongly");
  property p_timers_down;
    @(posedge aclk) disable iff (!aresetn)
      (cfg.pd[pm_pkg::PD_TIMA] && cfg.pd[pm_pkg::PD_TIMB]) |->
        misc_pad_oe[pm_pkg::P_TIN_B:pm_pkg::P_TOUT] == 4'h0 &&
        !timer_a_input && !timer_b_input;
  endproperty
  a_timers_down: assert property (p_timers_down)
    else $error("powered-down timer pins active");
endmodule // pin_mux_top

/* File: src/pm_pkg.sv */
// package: register map, field layout and encodings of the pin mux
package pm_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] SEL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] PWD_ADDR = 4'h4;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int HOST_PINS = 27;
  localparam int LINK_PINS = 10;
  localparam int ETH_PINS = 17;
  localparam int MISC_PINS = 8;
  localparam int SEL_W = 10;
  localparam logic [SEL_W-1:0] SEL_RESET = 10'h000;
  localparam int HOST_LSB = 0;
  localparam int UDATA_BIT = 3;
  localparam int FLOW_LSB = 4;
  localparam int TIMA_LSB = 6;
  localparam int TIMB_LSB = 8;
  localparam int PD_W = 5;
  localparam int PD_HOST = 0;
  localparam int PD_UDATA = 1;
  localparam int PD_FLOW = 2;
  localparam int PD_TIMA = 3;
  localparam int PD_TIMB = 4;
  localparam logic [PD_W-1:0] PD_RESET = 5'h1e;
  localparam logic [2:0] HOST_GPIO = 3'h0;
  localparam logic [2:0] HOST_HPI = 3'h1;
  localparam logic [2:0] HOST_LINK = 3'h2;
  localparam logic [2:0] HOST_BOTH = 3'h3;
  localparam logic [2:0] HOST_ETH = 3'h4;
  localparam logic UDATA_UART = 1'b1;
  localparam logic [1:0] FLOW_UART = 2'h1;
  localparam logic [1:0] FLOW_PWM = 2'h2;
  localparam logic [1:0] TIMA_TIMER = 2'h1;
  localparam logic [1:0] TIMA_CLOCK = 2'h3;
  localparam logic [1:0] TIMB_TIMER = 2'h1;
  localparam int P_RX = 0;
  localparam int P_TX = 1;
  localparam int P_CTS = 2;
  localparam int P_RTS = 3;
  localparam int P_TOUT = 4;
  localparam int P_TIN = 5;
  localparam int P_TOUT_B = 6;
  localparam int P_TIN_B = 7;
  localparam logic [MISC_PINS-1:0] MISC_DRIVE = 8'h5a;
  typedef enum logic [1:0] {
    FN_GPIO, FN_HOST_PORT, FN_SERIAL_LINK, FN_ETHERNET
  } pin_fn_type;
endpackage

/* File: src/pin_cfg_if.sv */
// interface: configuration fields and status between registers and mux
`timescale 1ns/10ps
interface pin_cfg_if;
  logic [2:0] host_group_select;
  logic uart_data_group_select;
  logic [1:0] uart_flow_group_select;
  logic [1:0] timer_a_group_select;
  logic [1:0] timer_b_group_select;
  logic [pm_pkg::PD_W-1:0] pd;
  logic [pm_pkg::PD_W-1:0] status;
  modport regs (
    output host_group_select, uart_data_group_select,
    output uart_flow_group_select, timer_a_group_select,
    output timer_b_group_select, pd,
    input status
  );
  modport mux (
    input host_group_select, uart_data_group_select,
    input uart_flow_group_select, timer_a_group_select,
    input timer_b_group_select, pd,
    output status
  );
endinterface

/* File: src/pin_mux_regs.sv */
// module: AXI4-Lite register file holding the pin selects and power downs
`timescale 1ns/10ps
module pin_mux_regs (
  input logic aclk,
  input logic aresetn,
  input logic [pm_pkg::ADDR_W-1:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  input logic [pm_pkg::ADDR_W-1:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready,
  pin_cfg_if.regs cfg
);
  logic aw_q, w_q, do_write;
  logic [pm_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [pm_pkg::SEL_W-1:0] sel_q;
  logic [pm_pkg::PD_W-1:0] pd_q;

  assign awready = !aw_q && !bvalid;
  assign wready = !w_q && !bvalid;
  assign arready = !rvalid;
  assign do_write = aw_q && w_q && !bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      aw_q <= 1'b0;
    else if (awvalid && awready)
    begin
      aw_q <= 1'b1;
      awaddr_q <= awaddr;
    end
    else if (do_write)
      aw_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      w_q <= 1'b0;
    else if (wvalid && wready)
    begin
      w_q <= 1'b1;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end
    else if (do_write)
      w_q <= 1'b0;
  end

  // selects and power downs; reset leaves only the host group powered
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sel_q <= pm_pkg::SEL_RESET;
      pd_q <= pm_pkg::PD_RESET;
    end
    else if (do_write && awaddr_q == pm_pkg::SEL_ADDR)
    begin
      if (wstrb_q[0])
        sel_q[7:0] <= wdata_q[7:0];
      if (wstrb_q[1])
        sel_q[pm_pkg::SEL_W-1:8] <= wdata_q[pm_pkg::SEL_W-1:8];
    end
    else if (do_write && awaddr_q == pm_pkg::PWD_ADDR && wstrb_q[0])
      pd_q <= wdata_q[pm_pkg::PD_W-1:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= pm_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid <= 1'b1;
      // status is read only: a write there is accepted and dropped
      if (awaddr_q == pm_pkg::SEL_ADDR || awaddr_q == pm_pkg::PWD_ADDR ||
          awaddr_q == pm_pkg::STAT_ADDR)
        bresp <= pm_pkg::RESP_OKAY;
      else
        bresp <= pm_pkg::RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= pm_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rresp <= pm_pkg::RESP_OKAY;
      case (araddr)
        pm_pkg::SEL_ADDR: rdata <= {22'h0, sel_q};
        pm_pkg::PWD_ADDR: rdata <= {27'h0, pd_q};
        pm_pkg::STAT_ADDR: rdata <= {27'h0, cfg.status};
        default:
        begin
          rdata <= 32'h0;
          rresp <= pm_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  assign cfg.host_group_select = sel_q[pm_pkg::HOST_LSB +: 3];
  assign cfg.uart_data_group_select = sel_q[pm_pkg::UDATA_BIT];
  assign cfg.uart_flow_group_select = sel_q[pm_pkg::FLOW_LSB +: 2];
  assign cfg.timer_a_group_select = sel_q[pm_pkg::TIMA_LSB +: 2];
  assign cfg.timer_b_group_select = sel_q[pm_pkg::TIMB_LSB +: 2];
  assign cfg.pd = pd_q;

  sequence s_released;
    $rose(aresetn);
  endsequence

  property p_host_up_at_reset;
    @(posedge aclk) disable iff (!aresetn)
      s_released |-> !pd_q[pm_pkg::PD_HOST] &&
        cfg.host_group_select == pm_pkg::HOST_GPIO;
  endproperty
  a_host_up_at_reset: assert property (p_host_up_at_reset)
    else $error("host group not powered up gpio after reset");

  property p_udata_reset;
    @(posedge aclk) disable iff (!aresetn)
      s_released |-> pd_q[pm_pkg::PD_UDATA] && !cfg.uart_data_group_select;
  endproperty
  a_udata_reset: assert property (p_udata_reset)
    else $error("uart data group wrong after reset");

  property p_flow_reset;
    @(posedge aclk) disable iff (!aresetn)
      s_released |-> pd_q[pm_pkg::PD_FLOW] &&
        cfg.uart_flow_group_select == 2'h0;
  endproperty
  a_flow_reset: assert property (p_flow_reset)
    else $error("flow group wrong after reset");

  property p_timers_reset;
    @(posedge aclk) disable iff (!aresetn)
      s_released |-> pd_q[pm_pkg::PD_TIMA] && pd_q[pm_pkg::PD_TIMB] &&
        cfg.timer_a_group_select == 2'h0 &&
        cfg.timer_b_group_select == 2'h0;
  endproperty
  a_timers_reset: assert property (p_timers_reset)
    else $error("timer groups wrong after reset");
endmodule // pin_mux_regs

/* File: tb/peripheral_pin_group_mux_tb_top.sv */
// testbench: register access and pin routing checks for the pin mux
`timescale 1ns/10ps
module peripheral_pin_group_mux_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd_v;
  logic [26:0] hp_in = 27'h3c5a5a5, hg_o = 27'h5555555, hpi_o = 27'h2aaaaaa;
  logic [26:0] hp_out, hp_oe, hg_in, hpi_in;
  logic [9:0] lk_o = 10'h3c3, lk_in;
  logic [16:0] eth_o = 17'h0f0f0, eth_in;
  // pad inputs high on every inward pin so a stuck-low path shows
  logic [7:0] mp_in = 8'hb5, mg_o = 8'h5a, mp_out, mp_oe, mg_in;
  logic fo = 1'b0;
  logic rx, cts, tain, ext, tbin;
  int fail_count = 0;
  int num_checks = 0;
  logic [31:0] sv [5] = '{32'h15a, 32'h0a3, 32'h2f4, 32'h001, 32'h005};
  logic [7:0] mk [5] = '{8'h5a, 8'h5a, 8'h4a, 8'h5a, 8'h5a};
  logic [7:0] ex [5] = '{8'h00, 8'h5a, 8'h4a, 8'h5a, 8'h5a};
  // misc gpio enables are the inverse of misc gpio levels so routed drives show; host enables equal their levels
  logic [7:0] oe [5] = '{8'h5a, 8'had, 8'h85, 8'ha5, 8'ha5};
  logic [7:0] gi [5] = '{8'h00, 8'hb5, 8'h85, 8'hb5, 8'hb5};
  logic [4:0] st [5] = '{5'h1f, 5'h05, 5'h09, 5'h01, 5'h00};
  logic [4:0] iw [5] = '{5'h1d, 5'h00, 5'h06, 5'h00, 5'h00};

  pin_mux_top dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .host_pad_in(hp_in), .host_pad_out(hp_out),
    .host_pad_oe(hp_oe), .host_gpio_out(hg_o), .host_gpio_oe(hg_o),
    .host_gpio_in(hg_in), .hpi_out(hpi_o), .hpi_oe(hpi_o), .hpi_in(hpi_in),
    .link_out(lk_o), .link_oe(lk_o), .link_in(lk_in), .eth_out(eth_o),
    .eth_oe(eth_o), .eth_in(eth_in), .misc_pad_in(mp_in),
    .misc_pad_out(mp_out), .misc_pad_oe(mp_oe), .misc_gpio_out(mg_o),
    .misc_gpio_oe(~mg_o), .misc_gpio_in(mg_in), .uart_receive_data(rx),
    .uart_transmit_data(fo), .uart_clear_to_send(cts),
    .uart_request_to_send(fo), .pulse_output_a(!fo), .timer_a_input(tain),
    .timer_a_output(fo), .serial_port_ext_clock(ext),
    .timer_b_input(tbin), .timer_b_output(fo)
  );

  always #25 aclk = ~aclk;

  function automatic logic [26:0] hexp(input logic [2:0] s);
    case (s)
      3'h1: return {hpi_o[26:1], hg_o[0]};
      3'h2: return {hg_o[26:10], lk_o};
      3'h3: return {eth_o, lk_o};
      3'h4: return {eth_o, hg_o[9:0]};
      default: return hg_o;
    endcase
  endfunction

  // host pins left on gpio for each host select code
  function automatic logic [26:0] gmask(input logic [2:0] s);
    case (s)
      3'h1: return 27'h0000001;
      3'h2: return 27'h7fffc00;
      3'h3: return 27'h0000000;
      3'h4: return 27'h00003ff;
      default: return 27'h7ffffff;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rd_v = rdata;
    rs = rresp;
    rready <= 1'b0;
    #1;
  endtask

  // misc outputs are compared only under the caller's mask m; inward pins have no defined out
  task automatic pins(input logic [2:0] h, input logic [7:0] m,
    input logic [7:0] e, input logic [4:0] w);
    chk(32'(hp_out), 32'(hexp(h)));
    chk(32'(hp_oe), 32'(hexp(h)));
    chk(32'(hg_in), 32'(hp_in & gmask(h)));
    chk(32'(hpi_in), 32'(h == 3'h1 ? hp_in & ~gmask(h) : 27'h0));
    chk(32'({eth_in, lk_in}), 32'(h == 3'h1 ? 27'h0 : hp_in & ~gmask(h)));
    chk(32'(mp_out & m), 32'(e));
    chk(32'({rx, cts, tain, ext, tbin}), 32'(w));
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(4'h0);
    chk(rd_v, 32'h0);
    rd(4'h4);
    chk(rd_v, 32'h1e);
    pins(3'h0, 8'hff, 8'h00, 5'h00);
    chk(32'(mp_oe), 32'h0);
    chk(32'(mg_in), 32'h0);
    $display("test reset done");
    wr(4'h4, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      // ethernet side stays quiet unless routed, no reduced pin set exists,
      // both uart data pins move together, clock pin routed in one case
      wr(4'h0, sv[i]);
      rd(4'h0);
      chk(rd_v, sv[i]);
      pins(sv[i][2:0], mk[i], ex[i], iw[i]);
      chk(32'(mp_oe), 32'(oe[i]));
      chk(32'(mg_in), 32'(gi[i]));
      rd(4'h8);
      chk(rd_v, 32'(st[i]));
    end
    $display("test routing done");
    wr(4'h4, 32'h1f);
    chk(32'(hp_out), 32'h0);
    chk(32'(hp_oe), 32'h0);
    chk(32'(hg_in), 32'h0);
    // unmapped offset: error response, nothing stored
    wr(4'hc, 32'h1);
    chk(32'(rs), 32'h2);
    rd(4'hc);
    chk(32'(rs), 32'h2);
    chk(rd_v, 32'h0);
    $display("test power and errors done");
    finish_test;
  end

  // whole run is about 80 cycles; generous margin before giving up
  initial
  begin
    repeat (4000) @(posedge aclk);
    fail_count++;
    finish_test;
  end
endmodule // peripheral_pin_group_mux_tb_top
